// file: hdl/irq_pin_cfg_pkg.sv
package irq_pin_cfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************

  // Register offsets on the serial configuration port.
  localparam logic [6:0] IRQ_PIN_CONFIG_ADDR    = 7'h7D;
  localparam logic [6:0] WRITE_PROTECT_KEY_ADDR = 7'h7E;

  // Reset values.
  localparam logic [7:0] IRQ_PIN_CONFIG_RESET    = 8'h02;
  localparam logic [7:0] WRITE_PROTECT_KEY_RESET = 8'h85;

  // Field positions inside the pin configuration register.
  localparam int unsigned POLARITY_BIT              = 0;
  localparam int unsigned TRISTATE_SELECT_BIT       = 1;
  localparam int unsigned GENERAL_OUTPUT_SELECT_BIT = 2;

  // Implemented bits of the pin configuration register.
  localparam logic [7:0] IRQ_PIN_CONFIG_MASK = 8'h07;

  // Key values.
  localparam logic [7:0] KEY_FULLY_UNPROTECTED  = 8'h85;
  localparam logic [7:0] KEY_SINGLE_UNPROTECTED = 8'h86;

  // Protection modes decoded from the key.
  typedef enum logic [1:0] {
    PROTECTED          = 2'b00,
    FULLY_UNPROTECTED  = 2'b01,
    SINGLE_UNPROTECTED = 2'b10
  } protect_mode_t;

endpackage : irq_pin_cfg_pkg

// file: hdl/irq_pin_cfg_write_protect.sv
`timescale 1ns/1ps


module irq_pin_cfg_write_protect (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       irq_active,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            other_write_allowed,
  output logic      [1:0] protect_mode,
  output logic            irq_pin_out,
  output logic            irq_pin_oe
);

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [7:0] irq_pin_config_reg;
  logic [7:0] irq_pin_config_next;
  logic [7:0] write_protect_key_reg;
  logic [7:0] write_protect_key_next;
  logic [7:0] rd_data_next;

  // Decode the protection mode from a key value. Only two key values
  // open the lock; every other value keeps the other registers protected.
  function automatic irq_pin_cfg_pkg::protect_mode_t decode_mode(
    input logic [7:0] key
  );
    if (key == irq_pin_cfg_pkg::KEY_FULLY_UNPROTECTED)
      decode_mode = irq_pin_cfg_pkg::FULLY_UNPROTECTED;
    else if (key == irq_pin_cfg_pkg::KEY_SINGLE_UNPROTECTED)
      decode_mode = irq_pin_cfg_pkg::SINGLE_UNPROTECTED;
    else
      decode_mode = irq_pin_cfg_pkg::PROTECTED;
  endfunction : decode_mode

  // Match the port address against one register offset.
  function automatic logic addr_match(
    input logic [6:0] a,
    input logic [6:0] target
  );
    addr_match = (a == target);
  endfunction : addr_match

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Address decode and current protection state.
  irq_pin_cfg_pkg::protect_mode_t mode;
  assign mode = decode_mode(write_protect_key_reg);

  wire logic hit_cfg =
    addr_match(addr, irq_pin_cfg_pkg::IRQ_PIN_CONFIG_ADDR);
  wire logic hit_key =
    addr_match(addr, irq_pin_cfg_pkg::WRITE_PROTECT_KEY_ADDR);
  wire logic unlocked = (mode != irq_pin_cfg_pkg::PROTECTED);

  // ****************************************************************
  // Write gating
  // ****************************************************************

  // Key value that single mode falls back to after its one write. Any
  // value outside the two unlocking codes would do; zero is plainest.
  localparam logic [7:0] KEY_RELOCK = 8'h00;

  // A write to any register other than the key, which passes the lock.
  // Unmapped addresses count as well, so in single mode a stray write
  // uses up the one permitted write and software must re-arm.
  wire logic other_write = wr_en & ~hit_key & unlocked;

  // Pin configuration takes only its implemented bits.
  assign irq_pin_config_next = (other_write & hit_cfg)
    ? (wr_data & irq_pin_cfg_pkg::IRQ_PIN_CONFIG_MASK)
    : irq_pin_config_reg;

  // Key is writable in every mode and wins over the relock; single
  // mode relocks after one other write.
  assign write_protect_key_next =
    (wr_en & hit_key) ? wr_data :
    (other_write & (mode == irq_pin_cfg_pkg::SINGLE_UNPROTECTED))
      ? KEY_RELOCK : write_protect_key_reg;

  // ****************************************************************
  // Read path and flags
  // ****************************************************************

  // Read data mux; unmapped addresses read as zero.
  assign rd_data_next =
    hit_cfg ? irq_pin_config_reg :
    hit_key ? write_protect_key_reg : 8'h00;

  // Hold the last read value until the next read strobe.
  wire logic [7:0] rd_data_hold = rd_en ? rd_data_next : rd_data;

  // Read answer and write pass flags are pulses one cycle after the
  // strobe that caused them.
  wire logic rd_valid_next            = rd_en;
  wire logic other_write_allowed_next = other_write;

  // Mode follows the key that the next edge stores, so the mode output
  // and the key register always change on the same edge.
  irq_pin_cfg_pkg::protect_mode_t protect_mode_next;
  assign protect_mode_next = decode_mode(write_protect_key_next);

  // ****************************************************************
  // State
  // ****************************************************************

  // Pin configuration register; reset leaves the pin tri-stated when
  // inactive and active low.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_pin_config_reg <= irq_pin_cfg_pkg::IRQ_PIN_CONFIG_RESET;
    end
    else
    begin
      irq_pin_config_reg <= irq_pin_config_next;
    end
  end

  // Key register; reset leaves the device fully unprotected.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      write_protect_key_reg <=
        irq_pin_cfg_pkg::WRITE_PROTECT_KEY_RESET;
    end
    else
    begin
      write_protect_key_reg <= write_protect_key_next;
    end
  end

  // Read data output register.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= rd_data_hold;
    end
  end

  // Read answer pulse.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_valid_next;
    end
  end

  // Pulse for a non-key write that passed the lock.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      other_write_allowed <= 1'b0;
    end
    else
    begin
      other_write_allowed <= other_write_allowed_next;
    end
  end

  // Protection mode output, kept in step with the key register.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      protect_mode <= irq_pin_cfg_pkg::FULLY_UNPROTECTED;
    end
    else
    begin
      protect_mode <= protect_mode_next;
    end
  end

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************

  // Pin driver runs from the stored configuration. A new configuration
  // reaches the pin two edges after its write, an interrupt one edge
  // after it is raised.
  irq_pin_driver u_pin (
    .clk          (clk),
    .reset        (reset),
    .config_value (irq_pin_config_reg),
    .irq_active   (irq_active),
    .irq_pin_out  (irq_pin_out),
    .irq_pin_oe   (irq_pin_oe)
  );

endmodule : irq_pin_cfg_write_protect

// file: hdl/irq_pin_driver.sv
`timescale 1ns/1ps

// Registered driver for the interrupt pin.
module irq_pin_driver (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] config_value,
  input  wire logic       irq_active,
  output logic            irq_pin_out,
  output logic            irq_pin_oe
);

  // ****************************************************************
  // Pin level and enable
  // ****************************************************************

  // Decode the configuration fields.
  wire logic gpo_sel  =
    config_value[irq_pin_cfg_pkg::GENERAL_OUTPUT_SELECT_BIT];
  wire logic tri_sel  = config_value[irq_pin_cfg_pkg::TRISTATE_SELECT_BIT];
  wire logic polarity = config_value[irq_pin_cfg_pkg::POLARITY_BIT];

  // In output mode the pin is always asserted at the polarity level.
  wire logic asserted = gpo_sel | irq_active;

  // Active level follows polarity, inactive level is its inverse.
  wire logic level_next = asserted ? polarity : ~polarity;

  // Driven always, or only while asserted when tri-state is selected.
  wire logic oe_next = ~tri_sel | asserted;

  // Pin outputs come straight from flip-flops.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_pin_out <= 1'b1;
      irq_pin_oe  <= 1'b0;
    end
    else
    begin
      irq_pin_out <= level_next;
      irq_pin_oe  <= oe_next;
    end
  end

endmodule : irq_pin_driver

// file: verif/host_model.sv
`timescale 1ns/1ps
// ****
// Host on the configuration port.
// ****
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [6:0] addr,
  output logic      [7:0] wr_data
);
  // Strobes idle low from time zero.
  initial {wr_en, rd_en, addr, wr_data} = 17'h0;
  // One write pulse; released data is flipped.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {wr_en, addr, wr_data} = {1'b1, a, d};
    @(posedge clk) #1;
    {wr_en, wr_data} = {1'b0, ~d};
  endtask : wr
  // One read; data is taken while valid stands.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    {rd_en, addr} = {1'b1, a};
    @(posedge clk) #1;
    rd_en = 1'b0;
    d = rd_data;
  endtask : rd
endmodule : host_model

// file: verif/irq_pin_cfg_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Protection and pin checks.
// ****************************************************************
module irq_pin_cfg_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic       irq_active,
  input wire logic       rd_valid,
  input wire logic       other_write_allowed,
  input wire logic       irq_pin_out,
  input wire logic       irq_pin_oe,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] protect_mode
);
  // Key writes and writes to any other place.
  wire logic k_wr =
    wr_en && addr == irq_pin_cfg_pkg::WRITE_PROTECT_KEY_ADDR;
  wire logic o_wr =
    wr_en && addr != irq_pin_cfg_pkg::WRITE_PROTECT_KEY_ADDR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RD_VALID: assert property (rd_en |=> rd_valid)
    else $error("no read valid");
  AST_RD_QUIET: assert property (!rd_en
    |=> !rd_valid && $stable(rd_data)) else $error("stray read answer");
  AST_KEY_FULL: assert property (k_wr && wr_data == 8'h85
    |=> protect_mode == 2'h1) else $error("key 85 mode");
  AST_KEY_ONE: assert property (k_wr && wr_data == 8'h86
    |=> protect_mode == 2'h2) else $error("key 86 mode");
  AST_KEY_LOCK: assert property (k_wr
    && !(wr_data inside {8'h85, 8'h86})
    |=> protect_mode == 2'h0) else $error("key lock mode");
  AST_LOCKED: assert property (o_wr && protect_mode == 2'h0
    |=> !other_write_allowed) else $error("locked write passed");
  AST_SINGLE: assert property (o_wr && protect_mode == 2'h2
    |=> other_write_allowed && protect_mode == 2'h0)
    else $error("single write");
  AST_FULL: assert property (o_wr && protect_mode == 2'h1
    |=> other_write_allowed && protect_mode == 2'h1)
    else $error("full write");
  AST_PIN_ACTIVE: assert property (irq_active |=> irq_pin_oe)
    else $error("pin not driven");
  AST_PIN_STEADY: assert property (!wr_en && !$past(wr_en)
    && !$past(reset) && $stable(irq_active)
    |=> $stable(irq_pin_out) && $stable(irq_pin_oe))
    else $error("pin moved without cause");
endmodule : irq_pin_cfg_checker
bind irq_pin_cfg_write_protect irq_pin_cfg_checker chk (
  .clk                 (clk),
  .reset               (reset),
  .wr_en               (wr_en),
  .rd_en               (rd_en),
  .irq_active          (irq_active),
  .rd_valid            (rd_valid),
  .other_write_allowed (other_write_allowed),
  .irq_pin_out         (irq_pin_out),
  .irq_pin_oe          (irq_pin_oe),
  .addr                (addr),
  .wr_data             (wr_data),
  .rd_data             (rd_data),
  .protect_mode        (protect_mode)
);

// file: verif/irq_pin_cfg_write_protect_bench.sv
`timescale 1ns/1ps
module irq_pin_cfg_write_protect_bench;
  logic        clk, reset, irq_active, wr_en, rd_en, rd_valid, owa, po, oe;
  logic [1:0]  pm;
  logic [6:0]  addr;
  logic [7:0]  wr_data, rd_data, v, k;
  logic [31:0] lfsr = 32'hADA3CB66;
  int          failures = 0;
  int          total_checks = 0;
  irq_pin_cfg_write_protect uut (.clk(clk), .reset(reset), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .irq_active(irq_active),
    .rd_data(rd_data), .rd_valid(rd_valid), .other_write_allowed(owa),
    .protect_mode(pm), .irq_pin_out(po), .irq_pin_oe(oe));
  host_model host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
  // Expected {out, enable} of the pin.
  function automatic logic [1:0] pin(input logic [2:0] c, input logic i);
    return {(c[2] | i) ? c[0] : ~c[0], ~c[1] | c[2] | i};
  endfunction : pin
  // Next state of the stimulus shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Compare and count.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run.
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  // Clock and watchdog.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #20000;
    failures++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    {reset, irq_active} = 2'b10;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    host.rd(7'h7D, v);
    check(v, 8'h02);
    host.rd(7'h7E, v);
    check(v, 8'h85);
    check({6'h0, po, oe}, 8'h02);
    host.wr(7'h7E, 8'h85);
    for (int c = 0; c < 16; c++)
    begin
      lfsr = lfsr_next(lfsr);
      irq_active = c[3];
      host.wr(7'h7D, {lfsr[7:3], c[2:0]});
      repeat (2) @(posedge clk);
      #1;
      check({6'h0, po, oe}, {6'h0, pin(c[2:0], c[3])});
      host.rd(7'h7D, v);
      check(v, {5'h00, c[2:0]});
    end
    k = (lfsr[15:8] inside {8'h85, 8'h86}) ? 8'h00 : lfsr[15:8];
    host.wr(7'h7E, k);
    host.rd(7'h7E, v);
    check(v, k);
    host.wr(7'h7D, 8'h00);
    host.rd(7'h7D, v);
    check(v, 8'h07);
    host.wr(7'h7E, 8'h86);
    host.wr(7'h7D, 8'h03);
    host.wr(7'h7D, 8'h04);
    host.rd(7'h7D, v);
    check(v, 8'h03);
    check({6'h0, pm}, 8'h00);
    host.rd(7'h10, v);
    check(v, 8'h00);
    // Reset again in mid-run; both registers return to their defaults.
    @(posedge clk) #1 reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    host.rd(7'h7D, v);
    check(v, 8'h02);
    host.rd(7'h7E, v);
    check(v, 8'h85);
    check({6'h0, pm}, 8'h01);
    check({6'h0, po, oe}, {6'h0, pin(3'h2, irq_active)});
    stop_test();
  end
endmodule : irq_pin_cfg_write_protect_bench
